// [bpe_pkg.sv]
package bpe_pkg;
  localparam int CLK_NS = 10;
  // base period of the command timeout counter
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
  localparam int CAL_NS = 10000;
  localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] CAL_LAST = 10'(CAL_CYC - 1);

  localparam logic [15:0] ADR_SEED_HIGH = 16'h09C7;
  localparam logic [15:0] ADR_SEED_MID = 16'h09C8;
  localparam logic [15:0] ADR_SEED_LOW = 16'h09C9;
  localparam logic [15:0] ADR_LINK_B3 = 16'h09CF;
  localparam logic [15:0] ADR_LINK_B2 = 16'h09D0;
  localparam logic [15:0] ADR_LINK_B1 = 16'h09D1;
  localparam logic [15:0] ADR_LINK_B0 = 16'h09D2;
  localparam logic [31:0] LINK_RST = 32'h0000_0000;
  localparam logic [23:0] SEED_RST = 24'h00_0000;
  localparam logic [7:0] MAXLEN_RST = 8'h1F;

  localparam logic [15:0] RX_SINGLE = 16'h0000;
  localparam logic [15:0] RX_CONT = 16'hFFFF;

  // flag bit positions
  localparam int FLG_TX = 0;
  localparam int FLG_RX = 1;
  localparam int FLG_SYNC = 2;
  localparam int FLG_CRC = 3;
  localparam int FLG_TMO = 4;
  // second and third status byte positions, fourth byte codes
  localparam int S2_SYNC = 6;
  localparam int S2_OVER = 5;
  localparam int S2_CRC = 4;
  localparam int S2_ABORT = 3;
  localparam int S2_HDR = 2;
  localparam int S2_DONE = 1;
  localparam int S2_BUSY = 0;
  localparam int S3_SENT = 0;
  localparam logic [2:0] COR_ERR = 3'h0;
  localparam logic [2:0] COR_ONE = 3'h1;

  typedef enum logic [3:0] {
    OP_REG_WR = 4'h0,
    OP_REG_RD = 4'h1,
    OP_TX = 4'h2,
    OP_RX = 4'h3,
    OP_STBY = 4'h4,
    OP_CLR = 4'h5,
    OP_ROUTE = 4'h6,
    OP_PARAMS = 4'h7,
    OP_BASE = 4'h8
  } bpe_op_t;

  typedef enum logic [1:0] {
    PH_CAL = 2'b00,
    PH_STBY = 2'b01,
    PH_TX = 2'b10,
    PH_RX = 2'b11
  } bpe_phase_t;

  typedef struct packed {
    bpe_op_t op;
    logic [15:0] addr;
    logic [15:0] arg;
    logic [7:0] arg2;
  } bpe_cmd_t;

  typedef struct packed {
    logic bit_val;
    logic bit_vld;
    logic hdr;
    logic [7:0] len;
    logic fin;
    logic crc_ok;
    logic [7:0] rssi;
  } bpe_rx_t;

  typedef struct packed {
    logic [7:0] rssi;
    logic [7:0] st2;
    logic [7:0] st3;
    logic [7:0] st4;
    logic [7:0] rx_len;
    logic [7:0] rx_off;
    logic [7:0] rdata;
  } bpe_stat_t;
endpackage : bpe_pkg

// [bpe_engine.sv]
`timescale 1ns/10ps
`default_nettype none
module bpe_engine
  import bpe_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_cmd_vld,
  input wire bpe_cmd_t i_cmd,
  output logic o_busy,
  input wire bpe_rx_t i_rx,
  input wire logic i_tx_end,
  output logic o_tx_run,
  output logic o_rx_run,
  output logic [31:0] o_link_addr,
  output logic [23:0] o_seed,
  output logic [7:0] o_flags,
  output logic o_general_output_one,
  output bpe_stat_t o_stat
);

  typedef struct packed {
    bpe_phase_t phase;
    logic [31:0] link;
    logic [23:0] seed;
    logic [7:0] irq_en;
    logic [7:0] dio_map;
    logic [7:0] flags;
    logic [31:0] shift;
    logic [15:0] tmr;
    logic tmr_on;
    logic [6:0] div;
    logic [9:0] cal;
    logic [15:0] rx_mode;
    logic [7:0] max_len;
    logic crc_en;
    logic sync_en;
    logic [7:0] rx_base;
    logic in_pkt;
    bpe_stat_t stat;
  } bpe_state_t;

  bpe_state_t s_r;
  bpe_state_t s_nxt;

  logic tick;
  logic expire;
  logic sync_hit;
  logic [31:0] shift_in;

  assign tick = (s_r.div == TICK_LAST);
  assign expire = tick && s_r.tmr_on && (s_r.tmr == 16'h0001);
  assign shift_in = {s_r.shift[30:0], i_rx.bit_val};
  // in-packet bits must not retrigger a detection
  assign sync_hit = (s_r.phase == PH_RX) && !s_r.in_pkt && i_rx.bit_vld
    && (shift_in == s_r.link);

  always_comb
  begin
    logic [7:0] set;
    set = 8'h00;
    s_nxt = s_r;
    s_nxt.div = tick ? 7'h00 : s_r.div + 7'h01;
    if (tick && s_r.tmr_on)
    begin
      s_nxt.tmr = s_r.tmr - 16'h0001;
    end
    if (s_r.phase == PH_RX && i_rx.bit_vld)
    begin
      s_nxt.shift = shift_in;
    end
    unique case (s_r.phase)
      PH_CAL:
      begin
        s_nxt.cal = s_r.cal + 10'h001;
        if (s_r.cal == CAL_LAST)
        begin
          s_nxt.phase = PH_STBY;
        end
      end
      PH_STBY:
      begin
      end
      PH_TX:
      begin
        if (i_tx_end)
        begin
          set[FLG_TX] = 1'b1;
          s_nxt.stat.st3[S3_SENT] = 1'b1;
          s_nxt.stat.st2[S2_BUSY] = 1'b0;
          s_nxt.tmr_on = 1'b0;
          s_nxt.phase = PH_STBY;
        end
        else if (expire)
        begin
          set[FLG_TMO] = 1'b1;
          s_nxt.tmr_on = 1'b0;
          s_nxt.stat.st2[S2_BUSY] = 1'b0;
          s_nxt.phase = PH_STBY;
        end
      end
      PH_RX:
      begin
        // timeout only while no packet seen
        if (expire)
        begin
          set[FLG_TMO] = 1'b1;
          s_nxt.tmr_on = 1'b0;
          s_nxt.phase = PH_STBY;
        end
        if (sync_hit)
        begin
          set[FLG_SYNC] = 1'b1;
          s_nxt.stat.rssi = i_rx.rssi;
          s_nxt.stat.st4 = {5'h00, COR_ONE};
          s_nxt.stat.st2 = 8'h00;
          s_nxt.stat.st2[S2_SYNC] = s_r.sync_en;
          s_nxt.stat.st2[S2_BUSY] = 1'b1;
          s_nxt.tmr_on = 1'b0;
          s_nxt.in_pkt = 1'b1;
        end
        if (s_r.in_pkt && i_rx.hdr)
        begin
          s_nxt.stat.st2[S2_HDR] = 1'b1;
          s_nxt.stat.rx_len = i_rx.len;
          s_nxt.stat.st2[S2_OVER] = (i_rx.len > s_r.max_len);
        end
        if (s_r.in_pkt && i_rx.fin)
        begin
          set[FLG_RX] = 1'b1;
          set[FLG_CRC] = s_r.crc_en && !i_rx.crc_ok;
          // result kept, packet stays in buffer
          s_nxt.stat.st2[S2_CRC] = s_r.crc_en && !i_rx.crc_ok;
          s_nxt.stat.st2[S2_DONE] = 1'b1;
          s_nxt.stat.st2[S2_BUSY] = 1'b0;
          s_nxt.stat.rx_off = s_r.rx_base;
          s_nxt.in_pkt = 1'b0;
          if (s_r.rx_mode != RX_CONT)
          begin
            s_nxt.phase = PH_STBY;
          end
        end
      end
    endcase
    if (i_cmd_vld && s_r.phase != PH_CAL)
    begin
      unique case (i_cmd.op)
        OP_REG_WR:
        begin
          unique case (i_cmd.addr)
            ADR_LINK_B3: s_nxt.link[31:24] = i_cmd.arg[7:0];
            ADR_LINK_B2: s_nxt.link[23:16] = i_cmd.arg[7:0];
            ADR_LINK_B1: s_nxt.link[15:8] = i_cmd.arg[7:0];
            ADR_LINK_B0: s_nxt.link[7:0] = i_cmd.arg[7:0];
            ADR_SEED_HIGH: s_nxt.seed[23:16] = i_cmd.arg[7:0];
            ADR_SEED_MID: s_nxt.seed[15:8] = i_cmd.arg[7:0];
            ADR_SEED_LOW: s_nxt.seed[7:0] = i_cmd.arg[7:0];
            default: s_nxt.seed = s_r.seed;
          endcase
        end
        OP_REG_RD:
        begin
          unique case (i_cmd.addr)
            ADR_LINK_B3: s_nxt.stat.rdata = s_r.link[31:24];
            ADR_LINK_B2: s_nxt.stat.rdata = s_r.link[23:16];
            ADR_LINK_B1: s_nxt.stat.rdata = s_r.link[15:8];
            ADR_LINK_B0: s_nxt.stat.rdata = s_r.link[7:0];
            ADR_SEED_HIGH: s_nxt.stat.rdata = s_r.seed[23:16];
            ADR_SEED_MID: s_nxt.stat.rdata = s_r.seed[15:8];
            ADR_SEED_LOW: s_nxt.stat.rdata = s_r.seed[7:0];
            default: s_nxt.stat.rdata = 8'h00;
          endcase
        end
        OP_TX:
        begin
          s_nxt.phase = PH_TX;
          s_nxt.tmr = i_cmd.arg;
          s_nxt.tmr_on = (i_cmd.arg != 16'h0000);
          s_nxt.div = 7'h00;
          s_nxt.stat.st3 = 8'h00;
          s_nxt.stat.st2 = 8'h01;
          s_nxt.in_pkt = 1'b0;
        end
        OP_RX:
        begin
          s_nxt.phase = PH_RX;
          s_nxt.rx_mode = i_cmd.arg;
          s_nxt.tmr = i_cmd.arg;
          s_nxt.tmr_on = (i_cmd.arg != RX_SINGLE) && (i_cmd.arg != RX_CONT);
          s_nxt.div = 7'h00;
          s_nxt.shift = 32'h0000_0000;
          s_nxt.in_pkt = 1'b0;
          s_nxt.stat.st4 = {5'h00, COR_ERR};
        end
        OP_STBY:
        begin
          // abort of a running packet, both directions
          if (s_r.phase == PH_TX || s_r.in_pkt)
          begin
            s_nxt.stat.st2[S2_ABORT] = 1'b1;
          end
          s_nxt.stat.st2[S2_BUSY] = 1'b0;
          s_nxt.phase = PH_STBY;
          s_nxt.tmr_on = 1'b0;
          s_nxt.in_pkt = 1'b0;
        end
        OP_CLR:
        begin
        end
        OP_ROUTE:
        begin
          s_nxt.irq_en = i_cmd.arg[7:0];
          s_nxt.dio_map = i_cmd.arg2;
        end
        OP_PARAMS:
        begin
          s_nxt.max_len = i_cmd.arg[7:0];
          s_nxt.crc_en = i_cmd.arg[8];
          s_nxt.sync_en = i_cmd.arg[9];
        end
        OP_BASE:
        begin
          s_nxt.rx_base = i_cmd.arg[7:0];
        end
        default:
        begin
        end
      endcase
    end
    // masked clear; a same-cycle event wins
    if (i_cmd_vld && i_cmd.op == OP_CLR && s_r.phase != PH_CAL)
    begin
      s_nxt.flags = (s_r.flags & ~i_cmd.arg[7:0]) | (set & s_r.irq_en);
    end
    else
    begin
      s_nxt.flags = s_r.flags | (set & s_r.irq_en);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      s_r <= '0;
      s_r.phase <= PH_CAL;
      s_r.link <= LINK_RST;
      s_r.seed <= SEED_RST;
      s_r.max_len <= MAXLEN_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_busy = (s_r.phase == PH_CAL);
  assign o_tx_run = (s_r.phase == PH_TX);
  assign o_rx_run = (s_r.phase == PH_RX);
  assign o_link_addr = s_r.link;
  assign o_seed = s_r.seed;
  assign o_flags = s_r.flags;
  assign o_general_output_one = |(s_r.flags & s_r.dio_map);
  assign o_stat = s_r.stat;

  // checker-side busy count, kept apart from the calibration counter
  // so a stuck calibration shows up as a count past the limit
  logic [10:0] busy_cyc_r;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      busy_cyc_r <= 11'h000;
    end
    else if (o_busy)
    begin
      busy_cyc_r <= busy_cyc_r + 11'h001;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence tx_ends;
    (s_r.phase == PH_TX) && i_tx_end;
  endsequence
  sequence back_in_stby;
    (s_r.phase == PH_STBY);
  endsequence

  chk_tx_done_flag: assert property (
    tx_ends |=> back_in_stby and o_stat.st3[S3_SENT]
      and (o_flags[FLG_TX] == s_r.irq_en[FLG_TX]))
    else $error("transmit end did not finish properly");

  chk_tx_timeout: assert property (
    (s_r.phase == PH_TX) && expire && !i_tx_end && s_r.irq_en[FLG_TMO]
      |=> back_in_stby and o_flags[FLG_TMO])
    else $error("transmit timeout not taken");

  chk_flag_clear: assert property (
    (s_r.phase == PH_STBY) && i_cmd_vld && (i_cmd.op == OP_CLR)
      |=> o_flags == ($past(o_flags) & ~$past(i_cmd.arg[7:0])))
    else $error("flag clear touched wrong bits");

  chk_single_rx_end: assert property (
    (s_r.phase == PH_RX) && s_r.in_pkt && i_rx.fin && (s_r.rx_mode != RX_CONT)
      && !i_cmd_vld |=> back_in_stby)
    else $error("single receive did not return to standby");

  chk_cont_rx_stays: assert property (
    (s_r.phase == PH_RX) && s_r.in_pkt && i_rx.fin && (s_r.rx_mode == RX_CONT)
      && !i_cmd_vld |=> (s_r.phase == PH_RX) ##0 o_stat.st2[S2_DONE])
    else $error("continuous receive stopped");

  chk_sync_strength: assert property (
    sync_hit && !i_cmd_vld |=> o_stat.rssi == $past(i_rx.rssi)
      && o_stat.st4[2:0] == COR_ONE && !s_r.tmr_on)
    else $error("sync capture wrong");

  chk_dio_low: assert property (
    (s_r.phase == PH_STBY) && i_cmd_vld && (i_cmd.op == OP_CLR)
      && (i_cmd.arg[7:0] == 8'hFF) |=> !o_general_output_one)
    else $error("output one stayed high after clear");

  chk_cal_release: assert property (
    $fell(i_srst) |-> o_busy)
    else $error("busy not high after reset");

  chk_cal_bound: assert property (
    o_busy |-> (busy_cyc_r <= {1'b0, CAL_LAST}))
    else $error("calibration never ended");

  chk_oversize: assert property (
    (s_r.phase == PH_RX) && s_r.in_pkt && i_rx.hdr && !i_cmd_vld
      |=> o_stat.st2[S2_OVER] == ($past(i_rx.len) > s_r.max_len))
    else $error("oversize bit wrong");

endmodule : bpe_engine
`default_nettype wire

// [bpe_modem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module bpe_modem_model
  import bpe_pkg::*;
(
  input wire logic i_clk_sys,
  output bpe_rx_t o_rx,
  output logic o_tx_end
);
  logic sending;
  logic cur_bit;
  initial
  begin
    o_rx = '0;
    o_tx_end = 1'b0;
    sending = 1'b0;
    cur_bit = 1'b0;
  end
  // idle line flips every cycle so a stale bit never passes for data
  always @(negedge i_clk_sys)
  begin
    o_rx.bit_vld <= sending;
    o_rx.bit_val <= sending ? cur_bit : ~o_rx.bit_val;
  end
  task automatic send_sync(input logic [31:0] word);
    for (int i = 31; i >= 0; i--)
    begin
      @(posedge i_clk_sys);
      cur_bit = word[i];
      sending = 1'b1;
    end
    @(posedge i_clk_sys);
    sending = 1'b0;
  endtask : send_sync
  task automatic send_hdr(input logic [7:0] len);
    @(negedge i_clk_sys);
    o_rx.len = len;
    o_rx.hdr = 1'b1;
    @(negedge i_clk_sys);
    o_rx.hdr = 1'b0;
    o_rx.len = ~len;
  endtask : send_hdr
  task automatic send_fin(input logic ok);
    @(negedge i_clk_sys);
    o_rx.crc_ok = ok;
    o_rx.fin = 1'b1;
    @(negedge i_clk_sys);
    o_rx.fin = 1'b0;
    o_rx.crc_ok = ~ok;
  endtask : send_fin
  task automatic set_rssi(input logic [7:0] v);
    @(negedge i_clk_sys);
    o_rx.rssi = v;
  endtask : set_rssi
  task automatic tx_done();
    @(negedge i_clk_sys);
    o_tx_end = 1'b1;
    @(negedge i_clk_sys);
    o_tx_end = 1'b0;
  endtask : tx_done
endmodule : bpe_modem_model
`default_nettype wire

// [ble_packet_engine_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module ble_packet_engine_control_tb;
  import bpe_pkg::*;
  localparam logic [31:0] LINK = 32'hA5C3_5A96;
  localparam logic [23:0] SEED = 24'h3C_96E1;
  logic clk, srst, cmd_vld, tx_end, busy, tx_run, rx_run, general_output_one;
  bpe_cmd_t cmd_r;
  bpe_rx_t rx;
  logic [31:0] link;
  logic [23:0] seed;
  logic [7:0] flags;
  bpe_stat_t st;
  int err_total = 0;
  int samples_checked = 0;
  bpe_engine uut (.i_clk_sys(clk), .i_srst(srst), .i_cmd_vld(cmd_vld), .i_cmd(cmd_r),
    .o_busy(busy), .i_rx(rx), .i_tx_end(tx_end), .o_tx_run(tx_run), .o_rx_run(rx_run),
    .o_link_addr(link), .o_seed(seed), .o_flags(flags), .o_general_output_one(general_output_one), .o_stat(st));
  bpe_modem_model modem (.i_clk_sys(clk), .o_rx(rx), .o_tx_end(tx_end));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cmd(input bpe_op_t op, input logic [15:0] a, input logic [15:0] g,
    input logic [7:0] g2);
    @(negedge clk);
    cmd_vld = 1'b1;
    cmd_r = '{op, a, g, g2};
    @(negedge clk);
    cmd_vld = 1'b0;
  endtask : cmd
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic t_calib();
    int n;
    n = 0;
    srst = 1'b1;
    cyc(6);
    srst = 1'b0;
    chk("busy_after_reset", 1, busy);
    while (busy !== 1'b0 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    chk("calib_len", 1, n >= CAL_CYC - 1 && n <= CAL_CYC + 1);
  endtask : t_calib
  task automatic t_regs();
    for (int i = 0; i < 4; i++)
      cmd(OP_REG_WR, ADR_LINK_B3 + 16'(i), {8'h00, LINK[31-8*i -: 8]}, 8'h00);
    for (int i = 0; i < 3; i++)
      cmd(OP_REG_WR, ADR_SEED_HIGH + 16'(i), {8'h00, SEED[23-8*i -: 8]}, 8'h00);
    cmd(OP_REG_WR, 16'h09CA, 16'h00FF, 8'h00);
    chk("link", LINK, link);
    chk("seed", SEED, seed);
    cmd(OP_REG_RD, ADR_SEED_MID, 16'h0000, 8'h00);
    chk("rd_seed_mid", SEED[15:8], st.rdata);
    cmd(OP_REG_RD, 16'h09CA, 16'h0000, 8'h00);
    chk("rd_unmapped", 0, st.rdata);
  endtask : t_regs
  task automatic t_tx();
    int n;
    n = 0;
    cmd(OP_ROUTE, 16'h0000, 16'h001F, 8'h11);
    cmd(OP_TX, 16'h0000, 16'h0000, 8'h00);
    chk("tx_run", 1, tx_run);
    chk("tx_st2", 8'h01, st.st2);
    chk("tx_st3", 8'h00, st.st3);
    modem.tx_done();
    cyc(1);
    chk("tx_flags", 8'h01, flags);
    chk("tx_st3_done", 8'h01, st.st3);
    chk("tx_stby", 0, tx_run);
    chk("general_output_one_tx", 1, general_output_one);
    cmd(OP_CLR, 16'h0000, 16'h0001, 8'h00);
    chk("clr_tx", 8'h00, flags);
    chk("general_output_one_clr", 0, general_output_one);
    cmd(OP_TX, 16'h0000, 16'h0002, 8'h00);
    cyc(TICK_CYC - 5);
    chk("tx_tmo_early", 1, tx_run);
    while (tx_run !== 1'b0 && n < 3 * TICK_CYC)
    begin
      cyc(1);
      n++;
    end
    cyc(1);
    chk("tx_tmo_flag", 8'h10, flags);
    chk("tx_tmo_stby", 0, tx_run);
    chk("general_output_one_tmo", 1, general_output_one);
    cmd(OP_CLR, 16'h0000, 16'h00FF, 8'h00);
  endtask : t_tx
  task automatic t_rx_single();
    cmd(OP_PARAMS, 16'h0000, 16'h0310, 8'h00);
    cmd(OP_BASE, 16'h0000, 16'h0040, 8'h00);
    cmd(OP_RX, 16'h0000, RX_SINGLE, 8'h00);
    cyc(3 * TICK_CYC);
    chk("rx_no_tmo", 1, rx_run);
    modem.set_rssi(8'h5A);
    modem.send_sync(LINK);
    cyc(3);
    modem.set_rssi(8'h11);
    chk("sync_flag", 8'h04, flags);
    chk("rssi", 8'h5A, st.rssi);
    chk("st4", COR_ONE, st.st4);
    chk("st2_sync", 8'h41, st.st2);
    modem.send_hdr(8'h20);
    cyc(2);
    chk("rx_len", 8'h20, st.rx_len);
    modem.send_fin(1'b0);
    cyc(2);
    chk("rx_flags", 8'h0E, flags);
    chk("st2_bad", 8'h76, st.st2);
    chk("rx_off", 8'h40, st.rx_off);
    chk("rx_stby", 0, rx_run);
    chk("general_output_one_unmapped", 0, general_output_one);
    cmd(OP_CLR, 16'h0000, 16'h0002, 8'h00);
    chk("clr_part", 8'h0C, flags);
    cmd(OP_CLR, 16'h0000, 16'h00FF, 8'h00);
  endtask : t_rx_single
  task automatic t_rx_cont();
    cmd(OP_RX, 16'h0000, RX_CONT, 8'h00);
    modem.send_sync(LINK);
    modem.send_hdr(8'h10);
    modem.send_fin(1'b1);
    cyc(2);
    chk("cont_flags", 8'h06, flags);
    chk("cont_st2", 8'h46, st.st2);
    chk("cont_run", 1, rx_run);
    modem.send_sync(LINK);
    cyc(3);
    cmd(OP_STBY, 16'h0000, 16'h0000, 8'h00);
    chk("abort", 1, st.st2[S2_ABORT]);
    chk("abort_stby", 0, rx_run);
    cmd(OP_CLR, 16'h0000, 16'h00FF, 8'h00);
  endtask : t_rx_cont
  task automatic t_rx_timer();
    int n;
    n = 0;
    // checksum and the sync status bit off for this pass
    cmd(OP_PARAMS, 16'h0000, 16'h0008, 8'h00);
    cmd(OP_RX, 16'h0000, 16'h0003, 8'h00);
    cyc(TICK_CYC);
    modem.send_sync(LINK);
    cyc(1);
    chk("st2_nosync", 8'h01, st.st2);
    cyc(4 * TICK_CYC);
    chk("timer_stop", 1, rx_run);
    chk("timer_noflag", 8'h04, flags);
    modem.send_fin(1'b0);
    cyc(1);
    chk("timer_pkt_stby", 0, rx_run);
    chk("crc_off_flags", 8'h06, flags);
    chk("crc_off_st2", 8'h02, st.st2);
    cmd(OP_CLR, 16'h0000, 16'h00FF, 8'h00);
    cmd(OP_RX, 16'h0000, 16'h0001, 8'h00);
    while (rx_run !== 1'b0 && n < 3 * TICK_CYC)
    begin
      cyc(1);
      n++;
    end
    cyc(1);
    chk("rx_tmo_flag", 8'h10, flags);
    chk("rx_tmo_stby", 0, rx_run);
  endtask : t_rx_timer
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    srst = 1'b1;
    cmd_vld = 1'b0;
    cmd_r = '0;
    t_calib();
    t_regs();
    t_tx();
    t_rx_single();
    t_rx_cont();
    t_rx_timer();
    tally_and_finish();
  end
endmodule : ble_packet_engine_control_tb
`default_nettype wire
